// >>> design/tcrc_top.sv
// timer clock selection, interval timer, clock output and reset/sleep control
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "tcrc_regs.svh"
module tcrc_top
  import tcrc_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYCLES = `TCRC_HOLDOFF_MS * 1000 * `TCRC_CLK_MHZ
) (
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  // register port
  input  wire tcrc_bus_req_t bus_i,
  output logic [7:0]         rdata_o,
  // oscillator and supply pins
  input  wire logic          osc24_i,
  input  wire logic          osc32k_i,
  input  wire logic          external_clock_input_i,
  input  wire logic          supply_low_i,
  // processor side
  input  wire logic          global_irq_enable_i,
  input  wire logic          irq_pending_i,
  input  wire logic          watchdog_reset_i,
  output logic               processor_reset_o,
  output logic               processor_run_o,
  output logic               processor_clock_o,
  output logic [15:0]        boot_address_o,
  output logic               osc24_enable_o,
  // timer and clock outputs
  output logic               capture_timer_tick_o,
  output logic               interval_timer_tick_o,
  output logic               interval_irq_o,
  output logic               clock_output_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic src_pick(input logic [1:0] sel, input logic a, input logic b,
                                    input logic c, input logic d);
    logic r;
    case (sel)
      2'h0:    r = a;
      2'h1:    r = b;
      2'h2:    r = c;
      default: r = d;
    endcase
    return r;
  endfunction : src_pick

  function automatic tcrc_state_t reg_defaults(input tcrc_state_t st);
    tcrc_state_t r;
    r              = st;
    r.tmr_cfg      = `TCRC_TMR_CFG_RST;
    r.clock_output_sel   = `TCRC_CLOCK_OUTPUT_RST;
    r.cpu_sel      = 1'b0;
    r.watchdog_reset_flag         = 1'b0;
    r.power_on_reset_flag         = 1'b1;
    r.sleep        = 1'b0;
    r.stop         = 1'b0;
    r.reload_stage = 8'(`TCRC_RELOAD_RST);
    r.reload       = `TCRC_RELOAD_RST;
    r.cnt          = 12'h000;
    r.irq          = 1'b0;
    r.cpu_lvl      = 1'b0;
    r.clk_out      = 1'b0;
    r.rdata        = 8'h00;
    r.rec_cnt      = 2'h0;
    r.cpu_rst      = 1'b1;
    return r;
  endfunction : reg_defaults

  // ----------------------------------------------------------------
  // state and ticks
  // ----------------------------------------------------------------
  tcrc_state_t s_ff;
  tcrc_state_t nxt_s;
  logic [3:0]  rise;
  logic        t24;
  logic        cap_src;
  logic        itmr_src;
  logic        cpu_src;
  logic        cap_tick;
  logic        itmr_tick;
  logic        cpu_tick;
  logic        por_now;
  logic [3:0]  cap_n;
  logic [3:0]  itmr_n;

  assign rise     = s_ff.stab & ~s_ff.prev;
  assign t24      = rise[`TCRC_PIN_OSC24] & (s_ff.pwr != PWR_SLEEP);
  assign por_now  = s_ff.stab[`TCRC_PIN_SUPPLY];
  assign cap_src  = src_pick(s_ff.tmr_cfg[`TCRC_CAP_SEL], t24, rise[`TCRC_PIN_EXT],
                             rise[`TCRC_PIN_OSC32], 1'b0);
  assign cap_n    = 4'({1'b0, s_ff.tmr_cfg[`TCRC_CAP_DIV], 1'b0}) + 4'h2;
  assign itmr_src = src_pick(s_ff.tmr_cfg[`TCRC_ITMR_SEL], t24, rise[`TCRC_PIN_EXT],
                             rise[`TCRC_PIN_OSC32], cap_tick);
  assign itmr_n   = 4'({2'b00, s_ff.tmr_cfg[`TCRC_ITMR_DIV]}) + 4'h1;
  assign cpu_src  = s_ff.cpu_sel ? rise[`TCRC_PIN_EXT] : t24;

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  tcrc_clk_div u_cap_div (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (cap_src),
    .n_i       (cap_n),
    .tick_o    (cap_tick)
  );

  tcrc_clk_div u_itmr_div (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (itmr_src),
    .n_i       (itmr_n),
    .tick_o    (itmr_tick)
  );

  tcrc_clk_div u_cpu_div (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (cpu_src),
    .n_i       (`TCRC_CPU_HALF_DIV),
    .tick_o    (cpu_tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    // pin synchronisers, a change counts once stages two and three agree
    nxt_s.s1   = {supply_low_i, osc32k_i, external_clock_input_i, osc24_i};
    nxt_s.s2   = s_ff.s1;
    nxt_s.s3   = s_ff.s2;
    nxt_s.stab = (~(s_ff.s2 ^ s_ff.s3) & s_ff.s3) | ((s_ff.s2 ^ s_ff.s3) & s_ff.stab);
    nxt_s.prev = s_ff.stab;

    // processor clock, fast oscillator over eight by default
    if (cpu_tick) begin
      nxt_s.cpu_lvl = ~s_ff.cpu_lvl;
    end

    // register writes
    if (bus_i.wr) begin
      case (bus_i.addr)
        `TCRC_ADDR_CPU_CLK: nxt_s.cpu_sel    = bus_i.wdata[0];
        `TCRC_ADDR_TMR_CFG: nxt_s.tmr_cfg    = bus_i.wdata;
        `TCRC_ADDR_CLOCK_OUTPUT:  nxt_s.clock_output_sel = bus_i.wdata[1:0];
        `TCRC_ADDR_RLD_LO:  nxt_s.reload_stage = bus_i.wdata;
        `TCRC_ADDR_RLD_HI:  nxt_s.reload     = {bus_i.wdata[3:0], s_ff.reload_stage};
        `TCRC_ADDR_SCR: begin
          nxt_s.watchdog_reset_flag  = s_ff.watchdog_reset_flag & bus_i.wdata[`TCRC_SCR_WATCHDOG_RESET_FLAG];
          nxt_s.power_on_reset_flag  = s_ff.power_on_reset_flag & bus_i.wdata[`TCRC_SCR_POWER_ON_RESET_FLAG];
          nxt_s.sleep = bus_i.wdata[`TCRC_SCR_SLEEP];
          nxt_s.stop  = bus_i.wdata[`TCRC_SCR_STOP];
        end
        default: ;
      endcase
    end

    // register reads, data in the next cycle only
    nxt_s.rdata = 8'h00;
    if (bus_i.rd) begin
      case (bus_i.addr)
        `TCRC_ADDR_CPU_CLK: nxt_s.rdata = {7'h00, s_ff.cpu_sel};
        `TCRC_ADDR_TMR_CFG: nxt_s.rdata = s_ff.tmr_cfg;
        `TCRC_ADDR_CLOCK_OUTPUT:  nxt_s.rdata = {6'h00, s_ff.clock_output_sel};
        `TCRC_ADDR_RLD_LO:  nxt_s.rdata = s_ff.reload_stage;
        `TCRC_ADDR_RLD_HI:  nxt_s.rdata = {4'h0, s_ff.reload[11:8]};
        `TCRC_ADDR_SCR:     nxt_s.rdata = {global_irq_enable_i, 1'b0, s_ff.watchdog_reset_flag, s_ff.power_on_reset_flag,
                                           s_ff.sleep, 2'b00, s_ff.stop};
        default:            nxt_s.rdata = 8'h00;
      endcase
    end

    // interval down counter
    nxt_s.irq = 1'b0;
    if (itmr_tick) begin
      if (s_ff.cnt == 12'h000) begin
        nxt_s.cnt = s_ff.reload;
        nxt_s.irq = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt - 12'h001;
      end
    end

    // clock output mux
    nxt_s.clk_out = src_pick(s_ff.clock_output_sel, s_ff.stab[`TCRC_PIN_OSC24], s_ff.stab[`TCRC_PIN_EXT],
                             s_ff.stab[`TCRC_PIN_OSC32], s_ff.cpu_lvl);

    // power sequencing
    case (s_ff.pwr)
      PWR_HOLDOFF: begin
        nxt_s.cpu_rst  = 1'b1;
        nxt_s.hold_cnt = s_ff.hold_cnt + 32'h1;
        if (s_ff.hold_cnt >= 32'(HOLDOFF_CYCLES - 1)) begin
          nxt_s.pwr     = PWR_RUN;
          nxt_s.cpu_rst = 1'b0;
        end
      end
      PWR_RUN: begin
        nxt_s.cpu_rst = 1'b0;
        if (s_ff.stop) begin
          nxt_s.pwr = PWR_HALT;
        end else if (s_ff.sleep) begin
          nxt_s.pwr     = PWR_SLEEP;
          nxt_s.cpu_sel = 1'b0;
        end
      end
      PWR_SLEEP: begin
        nxt_s.cpu_sel = 1'b0;
        if (irq_pending_i) begin
          nxt_s.pwr     = PWR_RECOVER;
          nxt_s.rec_cnt = 2'h0;
        end
      end
      PWR_RECOVER: begin
        if (rise[`TCRC_PIN_OSC32]) begin
          nxt_s.rec_cnt = s_ff.rec_cnt + 2'h1;
          if ((s_ff.rec_cnt + 2'h1) == `TCRC_RECOVER_TICKS) begin
            nxt_s.pwr   = PWR_RUN;
            nxt_s.sleep = 1'b0;
          end
        end
      end
      PWR_HALT: nxt_s.pwr = PWR_HALT;
      default:  nxt_s.pwr = PWR_HOLDOFF;
    endcase

    // watchdog reset, blocked while the power-on flag stands
    if (watchdog_reset_i && !s_ff.power_on_reset_flag) begin
      nxt_s         = reg_defaults(nxt_s);
      nxt_s.power_on_reset_flag    = 1'b0;
      nxt_s.watchdog_reset_flag    = 1'b1;
      nxt_s.pwr     = PWR_RUN;
      nxt_s.cpu_rst = 1'b1;
    end

    // power-on reset from the supply monitor
    if (por_now) begin
      nxt_s          = reg_defaults(nxt_s);
      nxt_s.pwr      = PWR_HOLDOFF;
      nxt_s.hold_cnt = 32'h0;
      nxt_s.cpu_rst  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_ff          <= reg_defaults(tcrc_state_t'('0));
    end else begin
      s_ff          <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o               = s_ff.rdata;
  assign processor_reset_o     = s_ff.cpu_rst;
  assign processor_run_o       = (s_ff.pwr == PWR_RUN);
  assign processor_clock_o     = s_ff.cpu_lvl;
  assign boot_address_o        = `TCRC_BOOT_ADDR;
  assign osc24_enable_o        = (s_ff.pwr != PWR_SLEEP);
  assign capture_timer_tick_o  = cap_tick;
  assign interval_timer_tick_o = itmr_tick;
  assign interval_irq_o        = s_ff.irq;
  assign clock_output_o        = s_ff.clk_out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_unmapped_reads_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (bus_i.rd && !por_now && !(bus_i.addr inside {`TCRC_ADDR_CPU_CLK, `TCRC_ADDR_TMR_CFG, `TCRC_ADDR_CLOCK_OUTPUT,
      `TCRC_ADDR_RLD_LO, `TCRC_ADDR_RLD_HI, `TCRC_ADDR_SCR})) |=> (rdata_o == 8'h00))
    else $error("unmapped read returned nonzero");

  a_global_irq_enable_status_mirror_bit: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (bus_i.rd && bus_i.addr == `TCRC_ADDR_SCR && !por_now) |=> (rdata_o[7] == $past(global_irq_enable_i)))
    else $error("interrupt status bit does not mirror enable");

  a_irq_on_reload: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (interval_irq_o && !$past(por_now) && !$past(watchdog_reset_i)) |-> (s_ff.cnt == $past(s_ff.reload)))
    else $error("interrupt without reload value load");

  a_counter_decrements: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (itmr_tick && s_ff.cnt != 12'h000 && !por_now && !watchdog_reset_i) |=>
      (s_ff.cnt == $past(s_ff.cnt) - 12'h001) && !interval_irq_o)
    else $error("counter did not step down by one");

  a_power_on_reset_flag_never_set: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (!s_ff.power_on_reset_flag && !por_now) |=> !s_ff.power_on_reset_flag)
    else $error("power-on flag set by software");

  a_wdr_blocked_power_on_reset_flag: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (s_ff.power_on_reset_flag && watchdog_reset_i && !s_ff.watchdog_reset_flag) |=> !s_ff.watchdog_reset_flag)
    else $error("watchdog reset taken while power-on flag set");

  a_sleep_clk_forced: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (s_ff.pwr == PWR_SLEEP) |-> (!s_ff.cpu_sel && !osc24_enable_o && !processor_run_o))
    else $error("sleep did not force internal clock off");

  a_halt_holds_state: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (s_ff.pwr == PWR_HALT && !por_now && !(watchdog_reset_i && !s_ff.power_on_reset_flag)) |=> (s_ff.pwr == PWR_HALT))
    else $error("halt left without reset");

  a_por_status_value: assert property (
    @(posedge clk_sys_i)
    (!rst_n_i) |=> ({s_ff.watchdog_reset_flag, s_ff.power_on_reset_flag, s_ff.sleep, s_ff.stop} == 4'h4 && s_ff.pwr == PWR_HOLDOFF))
    else $error("power-on status value wrong");

endmodule : tcrc_top

// >>> inc/tcrc_regs.svh
// register offsets, field positions, reset values and timing counts of the timer clock and reset control
`ifndef TCRC_REGS_SVH
`define TCRC_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TCRC_ADDR_CPU_CLK   8'h30
`define TCRC_ADDR_TMR_CFG   8'h31
`define TCRC_ADDR_CLOCK_OUTPUT    8'h32
`define TCRC_ADDR_RLD_LO    8'h33
`define TCRC_ADDR_RLD_HI    8'h34
`define TCRC_ADDR_SCR       8'hFF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCRC_CAP_DIV        7:6
`define TCRC_CAP_SEL        5:4
`define TCRC_ITMR_DIV       3:2
`define TCRC_ITMR_SEL       1:0
`define TCRC_SCR_WATCHDOG_RESET_FLAG       5
`define TCRC_SCR_POWER_ON_RESET_FLAG       4
`define TCRC_SCR_SLEEP      3
`define TCRC_SCR_STOP       0
`define TCRC_PIN_OSC24      0
`define TCRC_PIN_EXT        1
`define TCRC_PIN_OSC32      2
`define TCRC_PIN_SUPPLY     3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TCRC_TMR_CFG_RST    8'h8F
`define TCRC_CLOCK_OUTPUT_RST     2'h0
`define TCRC_SCR_RST        8'h10
`define TCRC_RELOAD_RST     12'hFFF
`define TCRC_BOOT_ADDR      16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TCRC_CLK_MHZ        250
`define TCRC_HOLDOFF_MS     20
`define TCRC_RECOVER_TICKS  2'h3
`define TCRC_CPU_HALF_DIV   4'h4

`endif

// >>> inc/tcrc_pkg.sv
// types of the timer clock and reset control
package tcrc_pkg;

  // ----------------------------------------------------------------
  // power sequencing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PWR_HOLDOFF,
    PWR_RUN,
    PWR_SLEEP,
    PWR_RECOVER,
    PWR_HALT
  } tcrc_pwr_t;

  // ----------------------------------------------------------------
  // register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcrc_bus_req_t;

  // ----------------------------------------------------------------
  // module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } tcrc_div_state_t;

  typedef struct packed {
    logic [7:0]  tmr_cfg;
    logic [1:0]  clock_output_sel;
    logic        cpu_sel;
    logic        watchdog_reset_flag;
    logic        power_on_reset_flag;
    logic        sleep;
    logic        stop;
    logic [7:0]  reload_stage;
    logic [11:0] reload;
    logic [11:0] cnt;
    logic        irq;
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic [3:0]  s3;
    logic [3:0]  stab;
    logic [3:0]  prev;
    logic        cpu_lvl;
    logic        clk_out;
    logic [7:0]  rdata;
    logic [31:0] hold_cnt;
    logic [1:0]  rec_cnt;
    tcrc_pwr_t   pwr;
    logic        cpu_rst;
  } tcrc_state_t;

endpackage : tcrc_pkg

// >>> design/tcrc_clk_div.sv
// tick divider: one output pulse for every n input ticks
`timescale 1ns/1ps
module tcrc_clk_div
  import tcrc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // ticks
  input  wire logic       tick_i,
  input  wire logic [3:0] n_i,
  output logic            tick_o
);

  tcrc_div_state_t s_ff;
  tcrc_div_state_t nxt_s;

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.tick = 1'b0;
    if (tick_i) begin
      if ((s_ff.cnt + 4'h1) >= n_i) begin
        nxt_s.cnt  = 4'h0;
        nxt_s.tick = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick_o = s_ff.tick;

endmodule : tcrc_clk_div

// >>> tb/test_tcrc_top.sv
// self-checking testbench of the timer clock and reset control
`timescale 1ns/1ps
`include "tcrc_regs.svh"
module test_tcrc_top
  import tcrc_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic          clk_sys_i, rst_n_i, sup_low, global_irq_enable, pend, wdg;
  logic          osc24 = 1'b0, osc32 = 1'b0, ext = 1'b0, rd_seen = 1'b0;
  logic          prst, run, pclk, oen, cap_t, itm_t, irq, cko;
  tcrc_bus_req_t bus;
  logic [7:0]    rdata, r, r2, x;
  logic [15:0]   boot;
  logic [7:0]    exp_q[$];
  int            n_mismatch, checked, i;
  int            cyc = 0;
  int            src_p[3] = '{8, 12, 20};
  wire  [7:0]    obs = {oen, prst, run, cko, pclk, irq, itm_t, cap_t};

  tcrc_top #(.HOLDOFF_CYCLES(20)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata),
    .osc24_i(osc24), .osc32k_i(osc32), .external_clock_input_i(ext), .supply_low_i(sup_low),
    .global_irq_enable_i(global_irq_enable), .irq_pending_i(pend), .watchdog_reset_i(wdg),
    .processor_reset_o(prst), .processor_run_o(run), .processor_clock_o(pclk),
    .boot_address_o(boot), .osc24_enable_o(oen), .capture_timer_tick_o(cap_t),
    .interval_timer_tick_o(itm_t), .interval_irq_o(irq), .clock_output_o(cko)
  );

  // ----------------------------------------------------------------
  // clock, oscillator pins, timeout
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) osc24 <= ~osc24;
    if (cyc % 6 == 5) ext <= ~ext;
    if (cyc % 10 == 9) osc32 <= ~osc32;
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // read data monitor: oldest note against the answer cycle
  always @(posedge clk_sys_i) begin
    rd_seen <= bus.rd;
    if (rd_seen === 1'b1) cmp_rd(rdata, exp_q.pop_front());
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask : cmp_val

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] e);
    checked++;
    if (got !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask : cmp_rd

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus <= '0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus <= '0;
  endtask : rd_chk

  // cycles between the second and third rising edge of an observed signal
  task automatic gap(input int w, input int e);
    int   t, n, last, g;
    logic pv;
    pv = obs[w];
    n = 0;
    last = 0;
    g = 0;
    for (t = 0; t < 3000 && n < 3; t++) begin
      @(posedge clk_sys_i);
      if (obs[w] === 1'b1 && pv !== 1'b1) begin
        n++;
        g = t - last;
        last = t;
      end
      pv = obs[w];
    end
    cmp_val((n < 3) ? 32'hFFFF : 32'(g), 32'(e));
  endtask : gap

  task automatic wait_hi(input int w, input int lim);
    int t;
    for (t = 0; t < lim && obs[w] !== 1'b1; t++) @(posedge clk_sys_i);
    cmp_val({31'h0, obs[w]}, 32'h1);
  endtask : wait_hi

  task automatic lvl(input int w, input logic e);
    cmp_val({31'h0, obs[w]}, {31'h0, e});
  endtask : lvl

  task automatic wdog;
    @(posedge clk_sys_i);
    wdg <= 1'b1;
    @(posedge clk_sys_i);
    wdg <= 1'b0;
  endtask : wdog

  task automatic tally_and_finish;
    repeat (3) @(posedge clk_sys_i);
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n_i, sup_low, global_irq_enable, pend, wdg} = '0;
    bus = '0;
    n_mismatch = 0;
    checked = 0;
    r = 8'($urandom(32'hE9ED) % 15 + 1);
    r2 = r + 8'h10;
    x = 8'($urandom);
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_reg(`TCRC_ADDR_RLD_LO, r);
    wr_reg(`TCRC_ADDR_RLD_HI, 8'hF0);
    #1;
    lvl(6, 1'b1);
    lvl(5, 1'b0);
    wait_hi(5, 40);
    cmp_val({16'h0, boot}, 32'h0);
    rd_chk(`TCRC_ADDR_CPU_CLK, 8'h00);
    rd_chk(`TCRC_ADDR_TMR_CFG, 8'h8F);
    rd_chk(`TCRC_ADDR_CLOCK_OUTPUT, 8'h00);
    rd_chk(`TCRC_ADDR_SCR, 8'h10);
    rd_chk(8'h20, 8'h00);
    rd_chk(`TCRC_ADDR_RLD_LO, r);
    rd_chk(`TCRC_ADDR_RLD_HI, 8'h00);
    $display("test reset values done");
    wr_reg(`TCRC_ADDR_CLOCK_OUTPUT, 8'hFF);
    rd_chk(`TCRC_ADDR_CLOCK_OUTPUT, 8'h03);
    wr_reg(`TCRC_ADDR_TMR_CFG, x);
    rd_chk(`TCRC_ADDR_TMR_CFG, x);
    global_irq_enable <= 1'b1;
    rd_chk(`TCRC_ADDR_SCR, 8'h90);
    global_irq_enable <= 1'b0;
    wr_reg(`TCRC_ADDR_TMR_CFG, 8'h5A);
    wdog();
    rd_chk(`TCRC_ADDR_SCR, 8'h10);
    rd_chk(`TCRC_ADDR_TMR_CFG, 8'h5A);
    wr_reg(`TCRC_ADDR_SCR, 8'h30);
    rd_chk(`TCRC_ADDR_SCR, 8'h10);
    wr_reg(`TCRC_ADDR_SCR, 8'h00);
    rd_chk(`TCRC_ADDR_SCR, 8'h00);
    $display("test register access done");
    for (i = 0; i < 4; i++) begin
      wr_reg(`TCRC_ADDR_TMR_CFG, {i[1:0], 6'h00});
      gap(0, (2 * i + 2) * 8);
      wr_reg(`TCRC_ADDR_TMR_CFG, {4'h0, i[1:0], 2'h0});
      gap(1, (i + 1) * 8);
    end
    for (i = 0; i < 3; i++) begin
      wr_reg(`TCRC_ADDR_TMR_CFG, {2'h0, i[1:0], 4'h0});
      gap(0, 2 * src_p[i]);
      wr_reg(`TCRC_ADDR_TMR_CFG, {6'h00, i[1:0]});
      gap(1, src_p[i]);
      wr_reg(`TCRC_ADDR_CLOCK_OUTPUT, {6'h00, i[1:0]});
      gap(4, src_p[i]);
    end
    wr_reg(`TCRC_ADDR_TMR_CFG, 8'h30);
    gap(0, 32'hFFFF);
    wr_reg(`TCRC_ADDR_TMR_CFG, 8'h03);
    gap(1, 16);
    wr_reg(`TCRC_ADDR_CLOCK_OUTPUT, 8'h03);
    gap(4, 64);
    gap(3, 64);
    wr_reg(`TCRC_ADDR_TMR_CFG, 8'h00);
    gap(2, (r + 1) * 8);
    wr_reg(`TCRC_ADDR_RLD_LO, r2);
    rd_chk(`TCRC_ADDR_RLD_LO, r2);
    gap(2, (r + 1) * 8);
    wr_reg(`TCRC_ADDR_RLD_HI, 8'h00);
    gap(2, (r2 + 1) * 8);
    $display("test clocks and interval timer done");
    wr_reg(`TCRC_ADDR_CPU_CLK, 8'h01);
    rd_chk(`TCRC_ADDR_CPU_CLK, 8'h01);
    gap(3, 96);
    wr_reg(`TCRC_ADDR_SCR, 8'h08);
    repeat (5) @(posedge clk_sys_i);
    #1;
    lvl(5, 1'b0);
    lvl(7, 1'b0);
    @(posedge clk_sys_i);
    pend <= 1'b1;
    repeat (30) @(posedge clk_sys_i);
    #1;
    lvl(5, 1'b0);
    wait_hi(5, 100);
    @(posedge clk_sys_i);
    pend <= 1'b0;
    lvl(7, 1'b1);
    rd_chk(`TCRC_ADDR_CPU_CLK, 8'h00);
    rd_chk(`TCRC_ADDR_SCR, 8'h00);
    wr_reg(`TCRC_ADDR_CPU_CLK, 8'h01);
    gap(3, 96);
    $display("test sleep done");
    wr_reg(`TCRC_ADDR_TMR_CFG, 8'h55);
    wr_reg(`TCRC_ADDR_SCR, 8'h01);
    repeat (40) @(posedge clk_sys_i);
    #1;
    lvl(5, 1'b0);
    wdog();
    wait_hi(5, 20);
    rd_chk(`TCRC_ADDR_SCR, 8'h20);
    rd_chk(`TCRC_ADDR_TMR_CFG, 8'h8F);
    wr_reg(`TCRC_ADDR_SCR, 8'h20);
    rd_chk(`TCRC_ADDR_SCR, 8'h20);
    wr_reg(`TCRC_ADDR_SCR, 8'h00);
    rd_chk(`TCRC_ADDR_SCR, 8'h00);
    $display("test halt and watchdog done");
    @(posedge clk_sys_i);
    sup_low <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    #1;
    lvl(6, 1'b1);
    lvl(5, 1'b0);
    @(posedge clk_sys_i);
    sup_low <= 1'b0;
    wait_hi(5, 80);
    rd_chk(`TCRC_ADDR_SCR, 8'h10);
    rd_chk(`TCRC_ADDR_CLOCK_OUTPUT, 8'h00);
    $display("test supply monitor done");
    tally_and_finish();
  end

endmodule : test_tcrc_top
